/* File: design/tcm_range_map.sv */
// Purpose: Sorts digitised thermocouple readings into bands and codes, and maps output codes to loop current.
// Assumes: All inputs come from logic on clk_i; readings are linearised tenths of a degree.
// Notes: The reading path answers one edge after its strobe, the current path two; codes and bands hold until the next strobe.
`timescale 1ns/1ps
`default_nettype none
module tcm_range_map
#(
    parameter logic [8:0] T_TAIL_GAIN = tcm_pkg::TCM_TAIL_GAIN_ONE
)
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Temperature reading in.
    input wire logic t_stb_i,
    input wire tcm_pkg::tcm_sens_t t_sens_i,
    input wire tcm_pkg::tcm_code_t t_raw_i,
    // Temperature code out.
    output logic t_stb_o,
    output tcm_pkg::tcm_code_t t_code_o,
    output tcm_pkg::tcm_band_t t_band_o,
    output logic t_uflow_o,
    output logic t_oflow_o,
    output logic t_sens_err_o,
    // Output code in.
    input wire logic ao_stb_i,
    input wire tcm_pkg::tcm_code_t ao_code_i,
    input wire logic ao_4_20_i,
    // Loop current out.
    output logic ao_stb_o,
    output tcm_pkg::tcm_ua_t ao_ua_o,
    output tcm_pkg::tcm_band_t ao_band_o
);
    import tcm_pkg::*;

    typedef struct packed {
        logic stb;
        tcm_code_t code;
        tcm_band_t band;
        logic uflow;
        logic oflow;
        logic sens_err;
        logic ao_stb;
        tcm_code_t ao_code;
        logic ao_4_20;
    } tcm_st_t;

    tcm_st_t st_r;
    tcm_st_t st_nxt;

    tcm_ao_if ao_bus ();

    tcm_ao_map u_ao_map
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ao(ao_bus.mapper)
    );

    always_comb
    begin
        tcm_lim_t lim;
        int val;
        int tail;
        logic legal;
        lim = tcm_limits(t_sens_i);
        val = int'(t_raw_i);
        tail = 0;
        legal = (t_sens_i == TCM_SENS_S) || (t_sens_i == TCM_SENS_T) || (t_sens_i == TCM_SENS_U);
        st_nxt = st_r;
        st_nxt.stb = t_stb_i;
        st_nxt.uflow = 1'b0;
        st_nxt.oflow = 1'b0;
        st_nxt.sens_err = 1'b0;
        // Below the knee the offset from the knee is scaled by T_TAIL_GAIN/256; the default gain carries on the slope reached at the knee.
        if ((t_sens_i == TCM_SENS_T) && (t_raw_i < TCM_T_LIN_KNEE))
        begin
            tail = (val - int'(TCM_T_LIN_KNEE)) * int'(T_TAIL_GAIN);
            val = int'(TCM_T_LIN_KNEE) + (tail >>> TCM_TAIL_SHIFT);
        end
        if (t_stb_i)
        begin
            if (!legal)
            begin
                st_nxt.code = TCM_CODE_UNFL;
                st_nxt.band = TCM_BAND_UNFL;
                st_nxt.sens_err = 1'b1;
            end
            else if (val > int'(lim.over_hi))
            begin
                st_nxt.code = TCM_CODE_OVFL;
                st_nxt.band = TCM_BAND_OVFL;
                st_nxt.oflow = 1'b1;
            end
            else if (val > int'(lim.rated_hi))
            begin
                st_nxt.code = 16'(val);
                st_nxt.band = TCM_BAND_OVER;
            end
            else if (val >= int'(lim.rated_lo))
            begin
                st_nxt.code = 16'(val);
                st_nxt.band = TCM_BAND_RATED;
            end
            else if (val >= int'(lim.under_lo))
            begin
                st_nxt.code = 16'(val);
                st_nxt.band = TCM_BAND_UNDER;
            end
            else
            begin
                st_nxt.code = TCM_CODE_UNFL;
                st_nxt.band = TCM_BAND_UNFL;
                st_nxt.uflow = 1'b1;
            end
        end
        st_nxt.ao_stb = ao_stb_i;
        if (ao_stb_i)
        begin
            st_nxt.ao_code = ao_code_i;
            st_nxt.ao_4_20 = ao_4_20_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_r <= '{1'b0, 16'sh0000, TCM_BAND_RATED, 1'b0, 1'b0, 1'b0, 1'b0, 16'sh0000, 1'b0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // The request is registered here, so the mapper answers two edges after ao_stb_i.
    assign ao_bus.code = st_r.ao_code;
    assign ao_bus.range_4_20 = st_r.ao_4_20;
    assign ao_bus.stb = st_r.ao_stb;

    assign t_stb_o = st_r.stb;
    assign t_code_o = st_r.code;
    assign t_band_o = st_r.band;
    assign t_uflow_o = st_r.uflow;
    assign t_oflow_o = st_r.oflow;
    assign t_sens_err_o = st_r.sens_err;
    assign ao_stb_o = ao_bus.done;
    assign ao_ua_o = ao_bus.ua;
    assign ao_band_o = ao_bus.band;
endmodule : tcm_range_map
`default_nettype wire

/* File: inc/tcm_pkg.sv */
// Purpose: Shared types and limits for the thermocouple code range mapper.
// Assumes: One clock, all codes are 16-bit two's complement; temperature codes are tenths of a degree.
// Notes: Functional notes follow.
// Functional notes
// - Type T rated codes run from 4000 down to -2700, one count per tenth of a degree.
// - Type T codes 4001 to 5400 are overrange and anything above 5400 reads 32767.
// - Type T codes of -2701 or less are underrange, and below F0C4 hex they give underflow and 8000 hex.
// - Type T is linear from +400 to -230 degrees; below that point the offset is scaled by T_TAIL_GAIN/256, which keeps the slope at the default gain.
// - Type U rated codes run 6000 to -2000, overrange up to 8500, and above that 32767.
// - Type U codes of -2001 or less are underrange, and below F380 hex they give underflow and 8000 hex.
// - Type S rated band ends at -500, underrange runs to -1700, and below F95C hex gives underflow and 8000 hex.
// - Type S overrange runs up to 18500 and anything above reads 32767.
// - Output codes 0 to 27648 map linearly to 20 mA, 27649 to 32511 are overrange, 32512 up drive 0 mA.
// - In 4 to 20 mA negative codes down to E500 hex fall toward 0 mA, below that is underflow; 0 to 20 mA gives 0 mA.
package tcm_pkg;

    typedef logic signed [15:0] tcm_code_t;
    typedef logic [15:0] tcm_ua_t;

    typedef enum logic [1:0] {
        TCM_SENS_S = 2'h0,
        TCM_SENS_T = 2'h1,
        TCM_SENS_U = 2'h2
    } tcm_sens_t;

    typedef enum logic [4:0] {
        TCM_BAND_RATED = 5'h01,
        TCM_BAND_OVER = 5'h02,
        TCM_BAND_OVFL = 5'h04,
        TCM_BAND_UNDER = 5'h08,
        TCM_BAND_UNFL = 5'h10
    } tcm_band_t;

    typedef struct packed {
        tcm_code_t rated_hi;
        tcm_code_t rated_lo;
        tcm_code_t over_hi;
        tcm_code_t under_lo;
    } tcm_lim_t;

    localparam tcm_code_t TCM_CODE_OVFL = 16'sh7FFF;
    localparam tcm_code_t TCM_CODE_UNFL = 16'sh8000;

    localparam tcm_code_t TCM_S_RATED_HI = 16'sh451A;
    localparam tcm_code_t TCM_S_RATED_LO = 16'shFE0C;
    localparam tcm_code_t TCM_S_OVER_HI = 16'sh4844;
    localparam tcm_code_t TCM_S_UNDER_LO = 16'shF95C;

    localparam tcm_code_t TCM_T_RATED_HI = 16'sh0FA0;
    localparam tcm_code_t TCM_T_RATED_LO = 16'shF574;
    localparam tcm_code_t TCM_T_OVER_HI = 16'sh1518;
    localparam tcm_code_t TCM_T_UNDER_LO = 16'shF0C4;
    localparam tcm_code_t TCM_T_LIN_KNEE = 16'shF704;

    localparam tcm_code_t TCM_U_RATED_HI = 16'sh1770;
    localparam tcm_code_t TCM_U_RATED_LO = 16'shF830;
    localparam tcm_code_t TCM_U_OVER_HI = 16'sh2134;
    localparam tcm_code_t TCM_U_UNDER_LO = 16'shF380;

    localparam logic [8:0] TCM_TAIL_GAIN_ONE = 9'h100;
    localparam int TCM_TAIL_SHIFT = 8;

    localparam tcm_code_t TCM_AO_FS_CODE = 16'sh6C00;
    localparam tcm_code_t TCM_AO_OVFL_CODE = 16'sh7F00;
    localparam tcm_code_t TCM_AO_UNFL_CODE = 16'shE500;
    localparam tcm_ua_t TCM_AO_SPAN_0_20_UA = 16'h4E20;
    localparam tcm_ua_t TCM_AO_SPAN_4_20_UA = 16'h3E80;
    localparam tcm_ua_t TCM_AO_LIVE_ZERO_UA = 16'h0FA0;
    localparam tcm_ua_t TCM_AO_ZERO_UA = 16'h0000;

    function automatic tcm_lim_t tcm_limits(input tcm_sens_t sens);
        tcm_lim_t lim;
        unique case (sens)
            TCM_SENS_T: lim = '{TCM_T_RATED_HI, TCM_T_RATED_LO, TCM_T_OVER_HI, TCM_T_UNDER_LO};
            TCM_SENS_U: lim = '{TCM_U_RATED_HI, TCM_U_RATED_LO, TCM_U_OVER_HI, TCM_U_UNDER_LO};
            default: lim = '{TCM_S_RATED_HI, TCM_S_RATED_LO, TCM_S_OVER_HI, TCM_S_UNDER_LO};
        endcase
        return lim;
    endfunction : tcm_limits

endpackage : tcm_pkg

/* File: inc/tcm_ao_if.sv */
// Purpose: Carries an output code request to the current mapper and its answer back.
// Assumes: Both ends run on the same clock.
// Notes: stb and done are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
interface tcm_ao_if;
    tcm_pkg::tcm_code_t code;
    logic range_4_20;
    logic stb;
    tcm_pkg::tcm_ua_t ua;
    tcm_pkg::tcm_band_t band;
    logic done;

    modport requester
    (
        output code, range_4_20, stb,
        input ua, band, done
    );

    modport mapper
    (
        input code, range_4_20, stb,
        output ua, band, done
    );
endinterface : tcm_ao_if
`default_nettype wire

/* File: design/tcm_ao_map.sv */
// Purpose: Maps a 16-bit output code to a loop current in microamps and a band.
// Assumes: Request comes from logic on the same clock.
// Notes: Answer is registered one edge after the request.
`timescale 1ns/1ps
`default_nettype none
module tcm_ao_map
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Request and answer.
    tcm_ao_if.mapper ao
);
    import tcm_pkg::*;

    typedef struct packed {
        tcm_ua_t ua;
        tcm_band_t band;
        logic done;
    } tcm_ao_st_t;

    tcm_ao_st_t st_r;
    tcm_ao_st_t st_nxt;

    always_comb
    begin
        int prod;
        int quot;
        tcm_ua_t span;
        tcm_ua_t base;
        prod = 0;
        quot = 0;
        span = ao.range_4_20 ? TCM_AO_SPAN_4_20_UA : TCM_AO_SPAN_0_20_UA;
        base = ao.range_4_20 ? TCM_AO_LIVE_ZERO_UA : TCM_AO_ZERO_UA;
        st_nxt = st_r;
        st_nxt.done = ao.stb;
        if (ao.stb)
        begin
            prod = int'(ao.code) * int'(span);
            quot = prod / int'(TCM_AO_FS_CODE);
            if (ao.code >= TCM_AO_OVFL_CODE)
            begin
                st_nxt.ua = TCM_AO_ZERO_UA;
                st_nxt.band = TCM_BAND_OVFL;
            end
            else if (ao.code > TCM_AO_FS_CODE)
            begin
                st_nxt.ua = 16'(int'(base) + quot);
                st_nxt.band = TCM_BAND_OVER;
            end
            else if (ao.code >= 16'sh0000)
            begin
                st_nxt.ua = 16'(int'(base) + quot);
                st_nxt.band = TCM_BAND_RATED;
            end
            else if (!ao.range_4_20)
            begin
                st_nxt.ua = TCM_AO_ZERO_UA;
                st_nxt.band = TCM_BAND_UNDER;
            end
            else if (ao.code >= TCM_AO_UNFL_CODE)
            begin
                st_nxt.ua = 16'(int'(base) + quot);
                st_nxt.band = TCM_BAND_UNDER;
            end
            else
            begin
                st_nxt.ua = TCM_AO_ZERO_UA;
                st_nxt.band = TCM_BAND_UNFL;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_r <= '{TCM_AO_ZERO_UA, TCM_BAND_RATED, 1'b0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign ao.ua = st_r.ua;
    assign ao.band = st_r.band;
    assign ao.done = st_r.done;
endmodule : tcm_ao_map
`default_nettype wire

/* File: verif/tcm_range_map_monitor.sv */
// Purpose: Concurrent checks on the ports of the range mapper.
// Assumes: One clock, reset active high, default tail slope unless told otherwise.
// Notes: Bound to every tcm_range_map instance below.
`timescale 1ns/1ps
`default_nettype none
module tcm_range_map_monitor
#(
    parameter logic [8:0] T_TAIL_GAIN = tcm_pkg::TCM_TAIL_GAIN_ONE
)
(
    // Clock, reset and reading path.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic t_stb_i,
    input wire tcm_pkg::tcm_sens_t t_sens_i,
    input wire tcm_pkg::tcm_code_t t_raw_i,
    input wire logic t_stb_o,
    input wire tcm_pkg::tcm_code_t t_code_o,
    input wire tcm_pkg::tcm_band_t t_band_o,
    input wire logic t_uflow_o,
    input wire logic t_oflow_o,
    input wire logic t_sens_err_o,
    // Current path.
    input wire logic ao_stb_i,
    input wire tcm_pkg::tcm_code_t ao_code_i,
    input wire logic ao_4_20_i,
    input wire logic ao_stb_o,
    input wire tcm_pkg::tcm_ua_t ao_ua_o,
    input wire tcm_pkg::tcm_band_t ao_band_o
);
    import tcm_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_t_rated_pass: assert property (t_stb_i && t_sens_i == TCM_SENS_T && t_raw_i >= TCM_T_LIN_KNEE
        && t_raw_i <= TCM_T_RATED_HI |=> t_stb_o && t_code_o == $past(t_raw_i) && t_band_o == TCM_BAND_RATED)
        else $error("type T rated reading not passed through");
    a_t_overflow_code: assert property (t_stb_i && t_sens_i == TCM_SENS_T && t_raw_i > TCM_T_OVER_HI
        |=> t_oflow_o && t_code_o == TCM_CODE_OVFL && t_band_o == TCM_BAND_OVFL)
        else $error("type T overflow not reported");
    a_t_underflow_code: assert property (t_stb_i && t_sens_i == TCM_SENS_T && t_raw_i < TCM_T_UNDER_LO
        && T_TAIL_GAIN >= TCM_TAIL_GAIN_ONE |=> t_uflow_o && t_code_o == TCM_CODE_UNFL)
        else $error("type T underflow not reported");
    a_t_tail_slope: assert property (t_stb_i && t_sens_i == TCM_SENS_T && t_raw_i < TCM_T_LIN_KNEE
        && t_raw_i >= TCM_T_RATED_LO && T_TAIL_GAIN == TCM_TAIL_GAIN_ONE |=> t_code_o == $past(t_raw_i))
        else $error("type T tail slope not kept");
    a_u_underflow_flag: assert property (t_stb_i && t_sens_i == TCM_SENS_U && t_raw_i < TCM_U_UNDER_LO
        |=> t_uflow_o && t_band_o == TCM_BAND_UNFL) else $error("type U underflow not flagged");
    a_s_overflow_code: assert property (t_stb_i && t_sens_i == TCM_SENS_S && t_raw_i > TCM_S_OVER_HI
        |=> t_oflow_o && t_code_o == TCM_CODE_OVFL) else $error("type S overflow not reported");
    a_ao_overflow_zero: assert property (ao_stb_i && ao_code_i >= TCM_AO_OVFL_CODE
        |-> ##2 ao_stb_o && ao_ua_o == TCM_AO_ZERO_UA && ao_band_o == TCM_BAND_OVFL)
        else $error("output overflow does not drive zero");
    a_ao_negative_zero: assert property (ao_stb_i && !ao_4_20_i && ao_code_i < 16'sh0000
        |-> ##2 ao_stb_o && ao_ua_o == TCM_AO_ZERO_UA) else $error("negative code in 0-20 range not zero");
    a_sens_type_error: assert property (t_stb_i
        && !(t_sens_i inside {TCM_SENS_S, TCM_SENS_T, TCM_SENS_U}) |=> t_sens_err_o && t_band_o == TCM_BAND_UNFL)
        else $error("illegal sensor type not flagged");
endmodule : tcm_range_map_monitor
bind tcm_range_map tcm_range_map_monitor #(.T_TAIL_GAIN(T_TAIL_GAIN)) u_monitor (.clk_i(clk_i), .rst_i(rst_i),
    .t_stb_i(t_stb_i), .t_sens_i(t_sens_i), .t_raw_i(t_raw_i), .t_stb_o(t_stb_o), .t_code_o(t_code_o),
    .t_band_o(t_band_o), .t_uflow_o(t_uflow_o), .t_oflow_o(t_oflow_o), .t_sens_err_o(t_sens_err_o),
    .ao_stb_i(ao_stb_i),
    .ao_code_i(ao_code_i), .ao_4_20_i(ao_4_20_i), .ao_stb_o(ao_stb_o), .ao_ua_o(ao_ua_o), .ao_band_o(ao_band_o));
`default_nettype wire

/* File: verif/tcm_field_model.sv */
// Purpose: Sensor and actuator side model that feeds readings and output codes.
// Assumes: Same clock as the mapper; one request per call.
// Notes: Reading and output code lines are inverted after each request so a stale value never looks valid; sensor type and range select are held.
`timescale 1ns/1ps
`default_nettype none
module tcm_field_model
(
    // Clock.
    input wire logic clk_i,
    // Requests to the mapper.
    output logic t_stb_o,
    output tcm_pkg::tcm_sens_t t_sens_o,
    output tcm_pkg::tcm_code_t t_raw_o,
    output logic ao_stb_o,
    output tcm_pkg::tcm_code_t ao_code_o,
    output logic ao_4_20_o
);
    import tcm_pkg::*;
    initial
    begin
        t_stb_o = 1'b0;
        t_sens_o = TCM_SENS_S;
        t_raw_o = 16'sh0000;
        ao_stb_o = 1'b0;
        ao_code_o = 16'sh0000;
        ao_4_20_o = 1'b0;
    end
    task read_temp(input tcm_sens_t s, input tcm_code_t v);
        @(posedge clk_i);
        t_stb_o <= 1'b1;
        t_sens_o <= s;
        t_raw_o <= v;
        @(posedge clk_i);
        t_stb_o <= 1'b0;
        t_raw_o <= ~v;
    endtask : read_temp
    task drive_code(input tcm_code_t c, input logic r);
        @(posedge clk_i);
        ao_stb_o <= 1'b1;
        ao_code_o <= c;
        ao_4_20_o <= r;
        @(posedge clk_i);
        ao_stb_o <= 1'b0;
        ao_code_o <= ~c;
    endtask : drive_code
endmodule : tcm_field_model
`default_nettype wire

/* File: verif/thermocouple_code_range_mapper_test.sv */
// Purpose: Self-checking bench for the range mapper.
// Assumes: 125 MHz clock, default tail slope.
// Notes: Each scenario waits for the answer pulse under a bound.
`timescale 1ns/1ps
`default_nettype none
module thermocouple_code_range_mapper_test;
    import tcm_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic t_stb_i, t_stb_o, t_uflow_o, t_oflow_o, t_sens_err_o, ao_stb_i, ao_4_20_i, ao_stb_o;
    tcm_sens_t t_sens_i;
    tcm_code_t t_raw_i, t_code_o, ao_code_i;
    tcm_ua_t ao_ua_o;
    tcm_band_t t_band_o, ao_band_o;
    int n_fail = 0;
    int n_compared = 0;
    always #4 clk_i = ~clk_i;
    tcm_range_map DUT (.clk_i(clk_i), .rst_i(rst_i), .t_stb_i(t_stb_i), .t_sens_i(t_sens_i), .t_raw_i(t_raw_i),
        .t_stb_o(t_stb_o), .t_code_o(t_code_o), .t_band_o(t_band_o), .t_uflow_o(t_uflow_o), .t_oflow_o(t_oflow_o),
        .t_sens_err_o(t_sens_err_o), .ao_stb_i(ao_stb_i), .ao_code_i(ao_code_i), .ao_4_20_i(ao_4_20_i),
        .ao_stb_o(ao_stb_o), .ao_ua_o(ao_ua_o), .ao_band_o(ao_band_o));
    tcm_field_model P (.clk_i(clk_i), .t_stb_o(t_stb_i), .t_sens_o(t_sens_i), .t_raw_o(t_raw_i),
        .ao_stb_o(ao_stb_i), .ao_code_o(ao_code_i), .ao_4_20_o(ao_4_20_i));
    task summarize;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
    task automatic wait_hi(ref logic sig);
        for (int i = 0; i < 6; i++)
        begin
            @(negedge clk_i);
            if (sig === 1'b1)
                return;
        end
        n_fail++;
        $display("BAD t=%0t answer pulse exp 1 got %h", $time, sig);
        summarize();
    endtask : wait_hi
    task chk_t(input tcm_code_t ec, input tcm_band_t eb);
        n_compared++;
        if (t_code_o !== ec || t_band_o !== eb)
        begin
            n_fail++;
            $display("BAD t=%0t exp %h/%h got %h/%h", $time, ec, eb, t_code_o, t_band_o);
        end
    endtask : chk_t
    task chk_a(input tcm_ua_t eu, input tcm_band_t eb);
        n_compared++;
        if (ao_ua_o !== eu || ao_band_o !== eb)
        begin
            n_fail++;
            $display("BAD t=%0t exp %h/%h got %h/%h", $time, eu, eb, ao_ua_o, ao_band_o);
        end
    endtask : chk_a
    task chk_f(input logic [2:0] ef);
        n_compared++;
        if ({t_uflow_o, t_oflow_o, t_sens_err_o} !== ef)
        begin
            n_fail++;
            $display("BAD t=%0t flags exp %h got %h", $time, ef, {t_uflow_o, t_oflow_o, t_sens_err_o});
        end
    endtask : chk_f
    // Overflow and underflow replace the code; every other band passes the reading through.
    task run_t(input tcm_sens_t s, input tcm_code_t v, input tcm_band_t eb);
        logic bad_type;
        bad_type = !(s inside {TCM_SENS_S, TCM_SENS_T, TCM_SENS_U});
        P.read_temp(s, v);
        wait_hi(t_stb_o);
        chk_t(eb == TCM_BAND_OVFL ? TCM_CODE_OVFL : eb == TCM_BAND_UNFL ? TCM_CODE_UNFL : v, eb);
        chk_f({eb == TCM_BAND_UNFL && !bad_type, eb == TCM_BAND_OVFL, bad_type});
    endtask : run_t
    task run_a(input tcm_code_t c, input logic r, input tcm_ua_t eu, input tcm_band_t eb);
        P.drive_code(c, r);
        wait_hi(ao_stb_o);
        chk_a(eu, eb);
    endtask : run_a
    task test_type_t;
        run_t(TCM_SENS_T, 16'sh0FA0, TCM_BAND_RATED);
        run_t(TCM_SENS_T, 16'shF574, TCM_BAND_RATED);
        run_t(TCM_SENS_T, 16'sh1518, TCM_BAND_OVER);
        run_t(TCM_SENS_T, 16'sh1519, TCM_BAND_OVFL);
        run_t(TCM_SENS_T, 16'shF0C4, TCM_BAND_UNDER);
        run_t(TCM_SENS_T, 16'shF0C3, TCM_BAND_UNFL);
        run_t(TCM_SENS_T, 16'shF704, TCM_BAND_RATED);
        $display("test type_t done");
    endtask : test_type_t
    task test_type_u_s;
        run_t(TCM_SENS_U, 16'sh1770, TCM_BAND_RATED);
        run_t(TCM_SENS_U, 16'sh2134, TCM_BAND_OVER);
        run_t(TCM_SENS_U, 16'sh2135, TCM_BAND_OVFL);
        run_t(TCM_SENS_U, 16'shF82F, TCM_BAND_UNDER);
        run_t(TCM_SENS_U, 16'shF37F, TCM_BAND_UNFL);
        run_t(TCM_SENS_S, 16'shFE0C, TCM_BAND_RATED);
        run_t(TCM_SENS_S, 16'shF95C, TCM_BAND_UNDER);
        run_t(TCM_SENS_S, 16'shF95B, TCM_BAND_UNFL);
        run_t(TCM_SENS_S, 16'sh4844, TCM_BAND_OVER);
        run_t(TCM_SENS_S, 16'sh4845, TCM_BAND_OVFL);
        run_t(tcm_sens_t'(2'h3), 16'sh0010, TCM_BAND_UNFL);
        $display("test type_u_s done");
    endtask : test_type_u_s
    task test_current;
        run_a(16'sh6C00, 1'b1, 16'h4E20, TCM_BAND_RATED);
        run_a(16'sh3600, 1'b0, 16'h2710, TCM_BAND_RATED);
        run_a(16'sh7EFF, 1'b0, 16'h5BDD, TCM_BAND_OVER);
        run_a(16'sh7F00, 1'b1, 16'h0000, TCM_BAND_OVFL);
        run_a(16'shFFFF, 1'b1, 16'h0FA0, TCM_BAND_UNDER);
        run_a(16'shE500, 1'b1, 16'h0000, TCM_BAND_UNDER);
        run_a(16'shE4FF, 1'b1, 16'h0000, TCM_BAND_UNFL);
        run_a(16'shFFFF, 1'b0, 16'h0000, TCM_BAND_UNDER);
        $display("test current done");
    endtask : test_current
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk_t(16'sh0000, TCM_BAND_RATED);
        chk_a(16'h0000, TCM_BAND_RATED);
        test_type_t();
        test_type_u_s();
        test_current();
        summarize();
    end
endmodule : thermocouple_code_range_mapper_test
`default_nettype wire
